// ==== core/mict_top.sv ====
`include "mict_defs.svh"
`default_nettype none

// Summary of operation
// - self-refresh hold flag bit 8 resets to 1; clear at controller reset asserts dimm reset
// - flag set at controller reset keeps dram in self refresh through it
// - init-done bit 7, reset 0, tells power control unit controller is ready
// - bit 2, reset 0, enables dram clock output for all channels
// - bit 1, reset 1, drives dimm reset for all channels together
// - calibration register bit 31 reports calibration in progress
// - calibration starts only on a 0 to 1 change of start bit 30
// - hardware clears the start bit only at controller reset; software clears it and polls completion
// - bit 21 set ignores dll lock status during calibration
// - bit 20 set stops forcing the dll on during calibration
// - after evaluation trigger, wait count cycles in bits 15:0 before loading; a zero count waits one cycle
module mict_top
  import mict_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ctl_reset,
  // configuration space access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_ack,
  // dimm and dram control
  output logic dimm_reset,
  output logic dclk_enable,
  output logic refresh_enable,
  output logic io_train_reset,
  output logic selfrefresh_keep,
  output logic unwarned_reset,
  // power control unit
  output logic power_control_unit_init_done,
  // io calibration logic
  input wire logic io_dll_locked,
  input wire logic io_load_done,
  output logic io_dll_force_on,
  output logic io_eval_start,
  output logic io_load_start
);

  mict_init_t init_r;
  mict_init_t init_nxt;
  mict_cal_cfg_t cal_r;
  mict_cal_cfg_t cal_nxt;
  logic start_prev_r;
  logic cal_trig;
  logic cal_busy;
  logic cal_first_done;
  logic init_hit;
  logic cal_hit;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic sr_keep;
  logic unwarned;

  // a literal cannot be bit-selected, so the reset word is named first
  localparam logic [31:0] INIT_RST = `MICT_INIT_RESET;

  assign init_hit = (cfg_addr == `MICT_INIT_STATE_OFS);
  assign cal_hit = (cfg_addr == `MICT_CAL_TIMER_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // memory_init_state next value
  always_comb begin
    init_nxt = init_r;
    if (ctl_reset) begin
      // hold flag is sticky across controller reset; it decides the dimm reset
      init_nxt.init_done = 1'b0;
      init_nxt.io_train_rst = 1'b1;
      init_nxt.refresh_en = 1'b0;
      init_nxt.dclk_en = 1'b0;
      init_nxt.dimm_rst = !init_r.sr_hold;
    end else if (cfg_wr && init_hit) begin
      init_nxt.sr_hold = cfg_wdata[`MICT_INIT_SR_HOLD_BIT];
      init_nxt.init_done = cfg_wdata[`MICT_INIT_DONE_BIT];
      init_nxt.io_train_rst = cfg_wdata[`MICT_INIT_IO_TRAIN_RST_BIT];
      init_nxt.refresh_en = cfg_wdata[`MICT_INIT_REFRESH_EN_BIT];
      init_nxt.dclk_en = cfg_wdata[`MICT_INIT_DCLK_EN_BIT];
      init_nxt.dimm_rst = cfg_wdata[`MICT_INIT_DIMM_RST_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_r.sr_hold <= INIT_RST[`MICT_INIT_SR_HOLD_BIT];
      init_r.init_done <= INIT_RST[`MICT_INIT_DONE_BIT];
      init_r.io_train_rst <= INIT_RST[`MICT_INIT_IO_TRAIN_RST_BIT];
      init_r.refresh_en <= INIT_RST[`MICT_INIT_REFRESH_EN_BIT];
      init_r.dclk_en <= INIT_RST[`MICT_INIT_DCLK_EN_BIT];
      init_r.dimm_rst <= INIT_RST[`MICT_INIT_DIMM_RST_BIT];
    end else begin
      init_r <= init_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // impedance_cal_timer next value; busy and first-done bits are not writable
  always_comb begin
    cal_nxt = cal_r;
    if (ctl_reset) begin
      cal_nxt.start = 1'b0;
      cal_nxt.ign_lock = 1'b0;
      cal_nxt.no_force = 1'b0;
      cal_nxt.count = `MICT_CAL_COUNT_RESET;
    end else if (cfg_wr && cal_hit) begin
      cal_nxt.start = cfg_wdata[`MICT_CAL_START_BIT];
      cal_nxt.ign_lock = cfg_wdata[`MICT_CAL_IGN_LOCK_BIT];
      cal_nxt.no_force = cfg_wdata[`MICT_CAL_NO_FORCE_BIT];
      cal_nxt.count = cfg_wdata[`MICT_CAL_COUNT_MSB:`MICT_CAL_COUNT_LSB];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_r.start <= 1'b0;
      cal_r.ign_lock <= 1'b0;
      cal_r.no_force <= 1'b0;
      cal_r.count <= `MICT_CAL_COUNT_RESET;
    end else begin
      cal_r <= cal_nxt;
    end
  end

  // edge of the stored bit, not of the write, so rewriting 1 does nothing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      start_prev_r <= 1'b0;
    end else begin
      start_prev_r <= cal_r.start;
    end
  end

  // a rising edge while a calibration runs is dropped, not queued
  assign cal_trig = cal_r.start && !start_prev_r && !ctl_reset;

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequencer
  mict_cal_seq #(
    .CNT_W(CNT_W)
  ) u_cal_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clr(ctl_reset),
    .trig(cal_trig),
    .ign_lock(cal_r.ign_lock),
    .no_force(cal_r.no_force),
    .count(cal_r.count[CNT_W-1:0]),
    .io_dll_locked(io_dll_locked),
    .io_load_done(io_load_done),
    .io_dll_force_on(io_dll_force_on),
    .io_eval_start(io_eval_start),
    .io_load_start(io_load_start),
    .busy(cal_busy),
    .first_done(cal_first_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // controller reset tracking
  mict_rst_track u_rst_track (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ctl_reset(ctl_reset),
    .sr_hold(init_r.sr_hold),
    .refresh_en(init_r.refresh_en),
    .sr_keep(sr_keep),
    .unwarned(unwarned)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the request; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (cfg_rd && init_hit) begin
      rdata_nxt[`MICT_INIT_SR_HOLD_BIT] = init_r.sr_hold;
      rdata_nxt[`MICT_INIT_DONE_BIT] = init_r.init_done;
      rdata_nxt[`MICT_INIT_IO_TRAIN_RST_BIT] = init_r.io_train_rst;
      rdata_nxt[`MICT_INIT_REFRESH_EN_BIT] = init_r.refresh_en;
      rdata_nxt[`MICT_INIT_DCLK_EN_BIT] = init_r.dclk_en;
      rdata_nxt[`MICT_INIT_DIMM_RST_BIT] = init_r.dimm_rst;
    end else if (cfg_rd && cal_hit) begin
      rdata_nxt[`MICT_CAL_BUSY_BIT] = cal_busy;
      rdata_nxt[`MICT_CAL_START_BIT] = cal_r.start;
      rdata_nxt[`MICT_CAL_IGN_LOCK_BIT] = cal_r.ign_lock;
      rdata_nxt[`MICT_CAL_NO_FORCE_BIT] = cal_r.no_force;
      rdata_nxt[`MICT_CAL_FIRST_DONE_BIT] = cal_first_done;
      rdata_nxt[`MICT_CAL_COUNT_MSB:`MICT_CAL_COUNT_LSB] = cal_r.count;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= cfg_rd || cfg_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign cfg_rdata = rdata_r;
  assign cfg_ack = ack_r;
  assign dimm_reset = init_r.dimm_rst;
  assign dclk_enable = init_r.dclk_en;
  assign refresh_enable = init_r.refresh_en;
  assign io_train_reset = init_r.io_train_rst;
  assign power_control_unit_init_done = init_r.init_done;
  assign selfrefresh_keep = sr_keep;
  assign unwarned_reset = unwarned;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cal_write;
    cfg_wr && cal_hit && !ctl_reset;
  endsequence

  sequence s_start_rise;
    cal_r.start && !start_prev_r && !ctl_reset;
  endsequence

  chk_unwarned_dimm_reset: assert property (
    ctl_reset && !init_r.sr_hold |=> dimm_reset && unwarned_reset)
    else $error("dimm reset not asserted after unwarned reset");

  chk_sr_keep_hold: assert property (
    ctl_reset && init_r.sr_hold |=> !dimm_reset && selfrefresh_keep && init_r.sr_hold)
    else $error("self refresh not kept through controller reset");

  chk_init_done_write: assert property (
    cfg_wr && init_hit && !ctl_reset
      |=> power_control_unit_init_done == $past(cfg_wdata[`MICT_INIT_DONE_BIT]))
    else $error("init done output does not follow write");

  chk_dclk_enable_write: assert property (
    cfg_wr && init_hit && !ctl_reset
      |=> dclk_enable == $past(cfg_wdata[`MICT_INIT_DCLK_EN_BIT]))
    else $error("dram clock enable does not follow write");

  chk_dimm_reset_write: assert property (
    cfg_wr && init_hit && !ctl_reset
      |=> dimm_reset == $past(cfg_wdata[`MICT_INIT_DIMM_RST_BIT]))
    else $error("dimm reset does not follow write");

  chk_busy_readback: assert property (
    cfg_rd && cal_hit |=> cfg_rdata[`MICT_CAL_BUSY_BIT] == $past(cal_busy))
    else $error("busy bit read back wrong");

  chk_start_only_rise: assert property (
    $rose(cal_busy) |-> $past(cal_trig))
    else $error("calibration started without a rising start bit");

  chk_start_rise_runs: assert property (
    s_start_rise ##0 !cal_busy |=> cal_busy)
    else $error("rising start bit did not start calibration");

  chk_start_kept: assert property (
    !(cfg_wr && cal_hit) && !ctl_reset |=> $stable(cal_r.start))
    else $error("start bit changed without a write");

  chk_start_written: assert property (
    s_cal_write |=> cal_r.start == $past(cfg_wdata[`MICT_CAL_START_BIT]))
    else $error("start bit write lost");

  chk_busy_until_load: assert property (
    $fell(cal_busy) && !$past(ctl_reset) |-> $past(io_load_start && io_load_done))
    else $error("busy cleared before result load finished");

  chk_first_done_sticky: assert property (
    cal_first_done && !ctl_reset |=> cal_first_done)
    else $error("first completion bit dropped");

  chk_ctl_reset_clears: assert property (
    ctl_reset |=> !cal_first_done && !cal_busy && !cal_r.start)
    else $error("controller reset left calibration state");

endmodule
`default_nettype wire

// ==== include/mict_defs.svh ====
`ifndef MICT_DEFS_SVH
`define MICT_DEFS_SVH

// configuration space offsets
`define MICT_CAL_TIMER_OFS 12'h8c0
`define MICT_INIT_STATE_OFS 12'h8b0

// memory_init_state fields
`define MICT_INIT_SR_HOLD_BIT 8
`define MICT_INIT_DONE_BIT 7
`define MICT_INIT_IO_TRAIN_RST_BIT 5
`define MICT_INIT_REFRESH_EN_BIT 3
`define MICT_INIT_DCLK_EN_BIT 2
`define MICT_INIT_DIMM_RST_BIT 1
`define MICT_INIT_RESET 32'h0000_0122

// impedance_cal_timer fields
`define MICT_CAL_BUSY_BIT 31
`define MICT_CAL_START_BIT 30
`define MICT_CAL_IGN_LOCK_BIT 21
`define MICT_CAL_NO_FORCE_BIT 20
`define MICT_CAL_FIRST_DONE_BIT 16
`define MICT_CAL_COUNT_MSB 15
`define MICT_CAL_COUNT_LSB 0
`define MICT_CAL_COUNT_RESET 16'h0c00
`define MICT_CAL_RESET 32'h0000_0c00

`endif

// ==== include/mict_pkg.sv ====
`default_nettype none
package mict_pkg;

  typedef enum logic [2:0] {
    MICT_CAL_IDLE = 3'b000,
    MICT_CAL_LOCK = 3'b001,
    MICT_CAL_EVAL = 3'b010,
    MICT_CAL_WAIT = 3'b011,
    MICT_CAL_LOAD = 3'b100
  } mict_cal_state_t;

  typedef struct packed {
    logic sr_hold;
    logic init_done;
    logic io_train_rst;
    logic refresh_en;
    logic dclk_en;
    logic dimm_rst;
  } mict_init_t;

  typedef struct packed {
    logic start;
    logic ign_lock;
    logic no_force;
    logic [15:0] count;
  } mict_cal_cfg_t;

endpackage
`default_nettype wire

// ==== core/mict_rst_track.sv ====
`default_nettype none
module mict_rst_track
  import mict_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // controller reset and register state
  input wire logic ctl_reset,
  input wire logic sr_hold,
  input wire logic refresh_en,
  // results
  output logic sr_keep,
  output logic unwarned
);

  logic sr_keep_r;
  logic unwarned_r;

  ////////////////////////////////////////////////////////////////////////////
  // dram stays in self refresh until software turns refresh back on
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_keep_r <= 1'b0;
    end else if (ctl_reset) begin
      sr_keep_r <= sr_hold;
    end else if (refresh_en) begin
      sr_keep_r <= 1'b0;
    end
  end

  // reset without warning stays visible until the next controller reset with the hold flag set
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      unwarned_r <= 1'b0;
    end else if (ctl_reset) begin
      unwarned_r <= !sr_hold;
    end
  end

  assign sr_keep = sr_keep_r;
  assign unwarned = unwarned_r;

endmodule
`default_nettype wire

// ==== core/mict_cal_seq.sv ====
`default_nettype none
module mict_cal_seq
  import mict_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  // control
  input wire logic trig,
  input wire logic ign_lock,
  input wire logic no_force,
  input wire logic [CNT_W-1:0] count,
  // io calibration side
  input wire logic io_dll_locked,
  input wire logic io_load_done,
  output logic io_dll_force_on,
  output logic io_eval_start,
  output logic io_load_start,
  // status
  output logic busy,
  output logic first_done
);

  mict_cal_state_t state_r;
  logic [CNT_W-1:0] cnt_r;
  logic first_done_r;
  logic [CNT_W:0] hc_r;
  logic [CNT_W-1:0] lat_r;

  ////////////////////////////////////////////////////////////////////////////
  // sequence: dll lock, evaluate, wait, load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MICT_CAL_IDLE;
      cnt_r <= '0;
    end else if (clr) begin
      state_r <= MICT_CAL_IDLE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        MICT_CAL_IDLE: begin
          if (trig) begin
            state_r <= MICT_CAL_LOCK;
          end
        end
        MICT_CAL_LOCK: begin
          if (ign_lock || io_dll_locked) begin
            state_r <= MICT_CAL_EVAL;
          end
        end
        MICT_CAL_EVAL: begin
          cnt_r <= count;
          state_r <= MICT_CAL_WAIT;
        end
        MICT_CAL_WAIT: begin
          // a zero count still waits one cycle so results never load early
          if (cnt_r <= CNT_W'(1)) begin
            state_r <= MICT_CAL_LOAD;
          end else begin
            cnt_r <= cnt_r - CNT_W'(1);
          end
        end
        MICT_CAL_LOAD: begin
          if (io_load_done) begin
            state_r <= MICT_CAL_IDLE;
          end
        end
        default: begin
          state_r <= MICT_CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_done_r <= 1'b0;
    end else if (clr) begin
      first_done_r <= 1'b0;
    end else if (state_r == MICT_CAL_LOAD && io_load_done) begin
      first_done_r <= 1'b1;
    end
  end

  assign busy = (state_r != MICT_CAL_IDLE);
  assign first_done = first_done_r;
  assign io_dll_force_on = busy && !no_force;
  assign io_eval_start = (state_r == MICT_CAL_EVAL);
  assign io_load_start = (state_r == MICT_CAL_LOAD);

  ////////////////////////////////////////////////////////////////////////////
  // helper: cycles since the evaluate pulse, and the count it used
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hc_r <= '0;
      lat_r <= '0;
    end else if (state_r == MICT_CAL_EVAL) begin
      hc_r <= (CNT_W+1)'(1);
      lat_r <= (count == '0) ? CNT_W'(1) : count;
    end else if (hc_r != '1) begin
      hc_r <= hc_r + (CNT_W+1)'(1);
    end
  end

  chk_load_wait_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == MICT_CAL_LOAD && $past(state_r) == MICT_CAL_WAIT && !$past(clr)
      |-> hc_r == {1'b0, lat_r} + (CNT_W+1)'(1))
    else $error("load started after wrong wait");

  chk_force_on_dll: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == MICT_CAL_LOCK |-> io_dll_force_on == !no_force)
    else $error("dll force does not follow its control");

  chk_ignore_lock: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_r == MICT_CAL_LOCK && ign_lock && !clr |=> state_r == MICT_CAL_EVAL)
    else $error("lock status not ignored");

  chk_first_done_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(first_done_r) |-> $past(state_r) == MICT_CAL_LOAD && $past(io_load_done))
    else $error("first completion set without a load");

endmodule
`default_nettype wire

// ==== sim/mict_io_model.sv ====
`default_nettype none
module mict_io_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // pacing set by the bench, 8'hff lock delay means never locks
  input wire logic [7:0] lock_dly,
  input wire logic [7:0] load_dly,
  // calibration link
  input wire logic io_dll_force_on,
  input wire logic io_load_start,
  output logic io_dll_locked,
  output logic io_load_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lock_cnt_r;
  logic [7:0] load_cnt_r;
  //////////////////////////////////////////////////////////////////////////////
  // an unforced loop never locks, so a waiting sequencer would hang: the harsh case
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt_r <= 8'h00;
    end else if (!io_dll_force_on) begin
      lock_cnt_r <= 8'h00;
    end else if (lock_cnt_r != 8'hff) begin
      lock_cnt_r <= lock_cnt_r + 8'h01;
    end
  end
  assign io_dll_locked = io_dll_force_on && (lock_dly != 8'hff) && (lock_cnt_r >= lock_dly);
  //////////////////////////////////////////////////////////////////////////////
  // load finishes load_dly cycles into the request, prompt when zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_cnt_r <= 8'h00;
    end else if (!io_load_start) begin
      load_cnt_r <= 8'h00;
    end else begin
      load_cnt_r <= load_cnt_r + 8'h01;
    end
  end
  assign io_load_done = io_load_start && (load_cnt_r == load_dly);
endmodule
`default_nettype wire

// ==== sim/mict_top_tb.sv ====
`include "mict_defs.svh"
`default_nettype none
module mict_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, ctl_reset, cfg_wr, cfg_rd, cfg_ack, ign_now, ld_prev;
  logic [11:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, fd;
  logic dimm_reset, dclk_enable, refresh_enable, io_train_reset, selfrefresh_keep;
  logic unwarned_reset, init_done, io_dll_locked, io_load_done;
  logic io_dll_force_on, io_eval_start, io_load_start;
  logic [7:0] lock_dly, load_dly;
  int errors, cmp_count, cyc, eval_cyc, evals, loads;
  logic [31:0] rd_q[$];
  logic [31:0] cal_q[$];
  localparam logic [11:0] CAL = `MICT_CAL_TIMER_OFS;
  localparam logic [11:0] INI = `MICT_INIT_STATE_OFS;
  //////////////////////////////////////////////////////////////////////////////
  mict_top #(.CNT_W(16)) dut (.core_clk(core_clk), .rst_n(rst_n), .ctl_reset(ctl_reset),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .dimm_reset(dimm_reset),
    .dclk_enable(dclk_enable), .refresh_enable(refresh_enable),
    .io_train_reset(io_train_reset), .selfrefresh_keep(selfrefresh_keep),
    .unwarned_reset(unwarned_reset), .power_control_unit_init_done(init_done),
    .io_dll_locked(io_dll_locked), .io_load_done(io_load_done),
    .io_dll_force_on(io_dll_force_on), .io_eval_start(io_eval_start),
    .io_load_start(io_load_start));
  mict_io_model io_model (.core_clk(core_clk), .rst_n(rst_n), .lock_dly(lock_dly),
    .load_dly(load_dly), .io_dll_force_on(io_dll_force_on), .io_load_start(io_load_start),
    .io_dll_locked(io_dll_locked), .io_load_done(io_load_done));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one access; a write notes zero read data, a read notes what must come back
  task automatic cfg(input logic wr, input logic [11:0] a, input logic [31:0] d,
      input logic [31:0] exp);
    @(posedge core_clk);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_addr <= a;
    cfg_wdata <= d;
    rd_q.push_back(wr ? 32'h0000_0000 : exp);
    @(posedge core_clk);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic ctl_pulse();
    @(posedge core_clk);
    ctl_reset <= 1'b1;
    @(posedge core_clk);
    ctl_reset <= 1'b0;
    @(posedge core_clk);
  endtask
  // start bit written 0 then 1, so every run begins on a clean rising edge
  task automatic cal_run(input logic ign, input logic nof, input logic [15:0] cnt,
      input logic [7:0] lk, input logic [7:0] ld);
    logic [31:0] v;
    int n;
    v = {10'h000, ign, nof, 4'h0, cnt};
    n = loads;
    lock_dly <= lk;
    load_dly <= ld;
    ign_now = ign;
    cal_q.push_back({!nof, 15'h0000, (cnt == 16'h0000) ? 16'h0002 : cnt + 16'h0001});
    cfg(1'b1, CAL, v, 32'h0000_0000);
    cfg(1'b1, CAL, v | 32'h4000_0000, 32'h0000_0000);
    if (cnt > 16'h0002) cfg(1'b0, CAL, 32'h0000_0000, v | 32'hc000_0000 | fd);
    for (int i = 0; i < 600 && loads == n; i++) @(posedge core_clk);
    for (int i = 0; i < 600 && io_load_start === 1'b1; i++) @(posedge core_clk);
    if (loads == n || io_load_start === 1'b1) begin
      check("calibration finish", 32'h0000_0000, 32'h0000_0001);
      complete_run();
    end
    fd = 32'h0001_0000;
    cfg(1'b0, CAL, 32'h0000_0000, v | 32'h4000_0000 | fd);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // watches acks and the calibration link against the notes left by the driver
  always @(posedge core_clk) begin
    cyc++;
    if (cfg_ack === 1'b1) begin
      if (rd_q.size() == 0) check("stray ack", 32'h0000_0001, 32'h0000_0000);
      else check("read data", cfg_rdata, rd_q.pop_front());
    end
    if (io_eval_start === 1'b1) begin
      eval_cyc = cyc;
      evals++;
      check("lock at eval", {31'h0, io_dll_locked | ign_now}, 32'h0000_0001);
    end
    if (io_load_start === 1'b1 && ld_prev !== 1'b1) begin
      loads++;
      if (cal_q.size() == 0) check("stray load", 32'h0000_0001, 32'h0000_0000);
      else check("eval to load", {io_dll_force_on, 15'h0, 16'(cyc - eval_cyc)},
        cal_q.pop_front());
    end
    ld_prev = io_load_start;
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] r;
    int n;
    {rst_n, ctl_reset, cfg_wr, cfg_rd, ign_now, ld_prev} = 6'b000000;
    cfg_addr = 12'h000;
    cfg_wdata = 32'h0000_0000;
    lock_dly = 8'h00;
    load_dly = 8'h00;
    fd = 32'h0000_0000;
    void'($urandom(32'h3c55c9f9));
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    check("reset outputs", {dimm_reset, dclk_enable, refresh_enable, io_train_reset, init_done,
      selfrefresh_keep, unwarned_reset}, 7'b1001000);
    cfg(1'b0, INI, 32'h0000_0000, 32'h0000_0122);
    cfg(1'b0, CAL, 32'h0000_0000, 32'h0000_0c00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      r = $urandom();
      cfg(1'b1, INI, r, 32'h0000_0000);
      cfg(1'b0, INI, 32'h0000_0000, r & 32'h0000_01ae);
      check("init outputs", {dimm_reset, dclk_enable, refresh_enable, io_train_reset,
        init_done}, {r[1], r[2], r[3], r[5], r[7]});
    end
    // unmapped place and read-only or reserved bits take no write
    cfg(1'b1, 12'h004, 32'hffff_ffff, 32'h0000_0000);
    cfg(1'b0, 12'h004, 32'h0000_0000, 32'h0000_0000);
    cfg(1'b0, INI, 32'h0000_0000, r & 32'h0000_01ae);
    cfg(1'b1, CAL, 32'h8221_0005, 32'h0000_0000);
    cfg(1'b0, CAL, 32'h0000_0000, 32'h0020_0005);
    $display("test register access done");
    cal_run(1'b0, 1'b0, 16'h0005, 8'h0c, 8'h03);
    cal_run(1'b1, 1'b0, 16'h0003, 8'h28, 8'h00);
    cal_run(1'b1, 1'b1, 16'h0000, 8'hff, 8'h00);
    cal_run(1'b0, 1'b0, 16'($urandom_range(3, 40)), 8'h02, 8'h05);
    n = evals;
    cfg(1'b1, CAL, 32'h4000_0005, 32'h0000_0000);
    cfg(1'b1, CAL, 32'h0000_0005, 32'h0000_0000);
    tick(20);
    check("start without rise", evals, n);
    $display("test calibration done");
    // a calibration stuck waiting for lock must be aborted by the controller reset
    lock_dly <= 8'hff;
    cfg(1'b1, CAL, 32'h4000_0005, 32'h0000_0000);
    cfg(1'b0, CAL, 32'h0000_0000, 32'hc001_0005);
    // unwarned controller reset: hold flag cleared on entry to init firmware
    cfg(1'b1, INI, 32'h0000_00ae, 32'h0000_0000);
    ctl_pulse();
    check("unwarned reset", {dimm_reset, selfrefresh_keep, unwarned_reset}, 3'b101);
    cfg(1'b0, INI, 32'h0000_0000, 32'h0000_0022);
    cfg(1'b0, CAL, 32'h0000_0000, 32'h0000_0c00);
    // warned reset keeps self refresh until refresh is enabled again
    cfg(1'b1, INI, 32'h0000_0126, 32'h0000_0000);
    ctl_pulse();
    check("warned reset", {dimm_reset, selfrefresh_keep, unwarned_reset}, 3'b010);
    cfg(1'b1, INI, 32'h0000_0108, 32'h0000_0000);
    tick(2);
    check("self refresh exit", {refresh_enable, selfrefresh_keep}, 2'b10);
    $display("test controller reset done");
    tick(4);
    // every noted read or load must have been answered
    check("pending notes", rd_q.size() + cal_q.size(), 32'h0000_0000);
    complete_run();
  end
endmodule
`default_nettype wire
